// *** nrzi_4b5b_5b6b_codec.sv ***
// serial character codec top: APB control, parallel ports, NRZI line
`timescale 1ns/1ps
`default_nettype none
module nrzi_4b5b_5b6b_codec (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] tx_parallel_word,
  input  wire logic        tx_special_char_select,
  input  wire logic        tx_write_enable,
  output logic             tx_busy,
  output logic             serial_out,
  input  wire logic        serial_in,
  input  wire logic        rx_port_enable,
  input  wire logic        rx_read_enable,
  output logic      [11:0] rx_parallel_word,
  output logic             rx_special_char_flag,
  output logic             rx_data_available,
  output logic             rx_word_oe,
  output logic             rx_char_error
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [2:0]  ctrl_reg;
  logic [2:0]  sticky_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        tx_en_d_reg;
  logic        tx_hold_valid_reg;
  logic [11:0] tx_hold_word_reg;
  logic        tx_hold_spec_reg;
  logic [11:0] tx_shift_reg;
  logic [3:0]  tx_cnt_reg;
  logic        serial_out_reg;
  logic        rx_sync1_reg;
  logic        rx_sync2_reg;
  logic        rx_prev_reg;
  logic [11:0] rx_window_reg;
  logic [3:0]  rx_cnt_reg;
  logic        rx_aligned_reg;
  logic        rx_pend_reg;
  logic [11:0] rx_hold_word_reg;
  logic        rx_hold_spec_reg;
  logic [11:0] rx_parallel_word_reg;
  logic        rx_special_reg;
  logic        rx_word_oe_reg;
  logic        rx_char_error_reg;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  logic        mode8_w;
  logic        ext_w;
  logic        bypass_w;
  logic        setup_w;
  logic        access_w;
  logic        hit_ctrl_w;
  logic        hit_status_w;
  logic        wr_ctrl_w;
  logic [2:0]  clear_w;
  logic [2:0]  set_w;
  logic [2:0]  sticky_next;
  logic [5:0]  status_w;
  logic [31:0] rd_data_w;

  assign mode8_w      = ctrl_reg[codec_pkg::CTRL_WIDTH8_BIT];
  assign ext_w        = ctrl_reg[codec_pkg::CTRL_EXTERNAL_FIFO_SELECT_BIT];
  assign bypass_w     = ctrl_reg[codec_pkg::CTRL_BYPASS_BIT];
  assign setup_w      = psel & ~penable;
  assign access_w     = psel & penable & pready_reg;
  assign hit_ctrl_w   = paddr == codec_pkg::ADDR_CTRL;
  assign hit_status_w = paddr == codec_pkg::ADDR_STATUS;
  assign wr_ctrl_w    = access_w & pwrite & hit_ctrl_w;
  assign clear_w      = (access_w & pwrite & hit_status_w)
                      ? pwdata[codec_pkg::ST_TXOVR_BIT:codec_pkg::ST_CHARERR_BIT]
                      : 3'h0;
  // set wins over a clear in the same cycle
  assign sticky_next  = (sticky_reg & ~clear_w) | set_w;
  assign status_w     = {sticky_reg, rx_aligned_reg, tx_hold_valid_reg,
                         rx_pend_reg};
  assign rd_data_w    = hit_ctrl_w ? {29'h0, ctrl_reg}
                      : hit_status_w ? {26'h0, status_w} : 32'h0;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg    <= codec_pkg::CTRL_RESET;
      sticky_reg  <= codec_pkg::STICKY_RESET;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      if (wr_ctrl_w) begin
        ctrl_reg <= pwdata[2:0];
      end
      sticky_reg  <= sticky_next;
      prdata_reg  <= (setup_w & ~pwrite) ? rd_data_w : 32'h0;
      pready_reg  <= setup_w;
      pslverr_reg <= setup_w & ~hit_ctrl_w & ~hit_status_w;
    end
  end

  // ----------------------------------------------------------------------
  // shared codec
  // ----------------------------------------------------------------------
  logic [11:0] enc_symbol_w;
  logic [11:0] rx_window_next;
  logic [11:0] dec_word_w;
  logic        dec_special_w;
  logic        dec_error_w;

  symbol_codec u_codec (
    .mode8       (mode8_w),
    .bypass      (bypass_w),
    .enc_word    (tx_hold_word_reg),
    .enc_special (tx_hold_spec_reg),
    .enc_symbol  (enc_symbol_w),
    .dec_symbol  (rx_window_next),
    .dec_word    (dec_word_w),
    .dec_special (dec_special_w),
    .dec_error   (dec_error_w)
  );

  // ----------------------------------------------------------------------
  // transmit capture and serializer
  // ----------------------------------------------------------------------
  logic        tx_cap_w;
  logic        tx_load_w;
  logic        tx_room_w;
  logic [3:0]  len_w;
  logic [11:0] tx_symbol_w;

  assign tx_cap_w    = ext_w ? tx_en_d_reg : ~tx_write_enable;
  assign tx_load_w   = tx_cnt_reg == 4'h0;
  assign tx_room_w   = ~tx_hold_valid_reg | tx_load_w;
  assign len_w       = mode8_w ? codec_pkg::SYM_LEN8 : codec_pkg::SYM_LEN10;
  // idle slots carry the sync symbol so the far receiver stays framed
  assign tx_symbol_w = tx_hold_valid_reg ? enc_symbol_w
                     : mode8_w ? {codec_pkg::SYNC8_SYMBOL, 2'b00}
                     : codec_pkg::SYNC10_SYMBOL;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_en_d_reg       <= 1'b0;
      tx_hold_valid_reg <= 1'b0;
      tx_hold_word_reg  <= 12'h000;
      tx_hold_spec_reg  <= 1'b0;
    end else begin
      tx_en_d_reg <= tx_write_enable;
      if (tx_cap_w & tx_room_w) begin
        tx_hold_valid_reg <= 1'b1;
        tx_hold_word_reg  <= tx_parallel_word;
        tx_hold_spec_reg  <= tx_special_char_select;
      end else if (tx_load_w) begin
        tx_hold_valid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tx_shift_reg   <= 12'h000;
      tx_cnt_reg     <= 4'h0;
      serial_out_reg <= 1'b0;
    end else begin
      tx_shift_reg   <= tx_load_w ? tx_symbol_w
                                  : {tx_shift_reg[10:0], 1'b0};
      tx_cnt_reg     <= tx_load_w ? len_w - 4'h1 : tx_cnt_reg - 4'h1;
      serial_out_reg <= serial_out_reg ^ tx_shift_reg[11];
    end
  end

  // ----------------------------------------------------------------------
  // receive line, framing and output port
  // ----------------------------------------------------------------------
  logic rx_bit_w;
  logic sync_hit_w;
  logic sym_done_w;
  logic rd_w;
  logic rx_store_w;

  assign rx_bit_w       = rx_sync2_reg ^ rx_prev_reg;
  assign rx_window_next = {rx_window_reg[10:0], rx_bit_w};
  assign sync_hit_w     = mode8_w
                        ? rx_window_next[9:0] == codec_pkg::SYNC8_SYMBOL
                        : rx_window_next == codec_pkg::SYNC10_SYMBOL;
  assign sym_done_w     = ~sync_hit_w & rx_aligned_reg
                        & (rx_cnt_reg == len_w - 4'h1);
  assign rd_w           = ~rx_read_enable & rx_word_oe_reg
                        & rx_pend_reg;
  assign rx_store_w     = sym_done_w & ~dec_error_w & (~rx_pend_reg | rd_w);
  assign set_w          = {tx_cap_w & ~tx_room_w,
                           sym_done_w & ~dec_error_w & rx_pend_reg & ~rd_w,
                           sym_done_w & dec_error_w};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_sync1_reg   <= 1'b0;
      rx_sync2_reg   <= 1'b0;
      rx_prev_reg    <= 1'b0;
      rx_window_reg  <= 12'h000;
      rx_cnt_reg     <= 4'h0;
      rx_aligned_reg <= 1'b0;
    end else begin
      rx_sync1_reg  <= serial_in;
      rx_sync2_reg  <= rx_sync1_reg;
      rx_prev_reg   <= rx_sync2_reg;
      rx_window_reg <= rx_window_next;
      if (sync_hit_w || rx_cnt_reg == len_w - 4'h1) begin
        rx_cnt_reg <= 4'h0;
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
      if (sync_hit_w) begin
        rx_aligned_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rx_pend_reg          <= 1'b0;
      rx_hold_word_reg     <= 12'h000;
      rx_hold_spec_reg     <= 1'b0;
      rx_parallel_word_reg <= 12'h000;
      rx_special_reg       <= 1'b0;
      rx_word_oe_reg       <= 1'b0;
      rx_char_error_reg    <= 1'b0;
    end else begin
      rx_word_oe_reg    <= rx_port_enable;
      rx_char_error_reg <= sym_done_w & dec_error_w;
      if (rx_store_w) begin
        rx_pend_reg      <= 1'b1;
        rx_hold_word_reg <= dec_word_w;
        rx_hold_spec_reg <= dec_special_w;
      end else if (rd_w) begin
        rx_pend_reg <= 1'b0;
      end
      if (rd_w) begin
        rx_parallel_word_reg <= rx_hold_word_reg;
        rx_special_reg       <= rx_hold_spec_reg & ~bypass_w;
      end
    end
  end

  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign tx_busy              = tx_hold_valid_reg;
  assign serial_out           = serial_out_reg;
  assign rx_parallel_word     = rx_parallel_word_reg;
  assign rx_special_char_flag = rx_special_reg;
  assign rx_data_available    = rx_pend_reg;
  assign rx_word_oe           = rx_word_oe_reg;
  assign rx_char_error        = rx_char_error_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  nrzi_tx_a: assert property (
    @(posedge clk) disable iff (!rstn)
    tx_load_w |-> ##2 ((serial_out_reg ^ $past(serial_out_reg))
                       == $past(tx_symbol_w[11], 2)))
    else $error("line did not toggle for a one bit");

  msb_first_a: assert property (
    @(posedge clk) disable iff (!rstn)
    tx_load_w |=> (tx_shift_reg == $past(tx_symbol_w)) ##1
                  (tx_shift_reg[11] == $past(tx_shift_reg[10])))
    else $error("symbol not sent msb first");

  fifo_capture_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (ext_w && tx_write_enable) ##1 (ext_w && tx_room_w)
      |=> tx_hold_valid_reg && tx_hold_word_reg == $past(tx_parallel_word))
    else $error("external fifo word not taken one cycle later");

  sync_capture_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (!ext_w && !tx_write_enable && tx_room_w)
      |=> tx_hold_valid_reg && tx_hold_word_reg == $past(tx_parallel_word))
    else $error("controller word not taken with its enable");

  rx_still_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (rx_read_enable || !rx_pend_reg) |=> $stable(rx_parallel_word_reg))
    else $error("receive word changed without a read");

  rx_read_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (!rx_read_enable && rx_word_oe_reg && rx_pend_reg)
      |=> rx_parallel_word_reg == $past(rx_hold_word_reg))
    else $error("enabled read did not present the word");

  rx_empty_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (rd_w && !sym_done_w) |=> !rx_data_available)
    else $error("available flag stayed high after last read");

  rx_hiz_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (!rx_word_oe_reg && rx_pend_reg)
      |=> rx_pend_reg && $stable(rx_parallel_word_reg))
    else $error("read taken while outputs disabled");

  bypass_flag_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (bypass_w && rd_w) |=> !rx_special_char_flag)
    else $error("special flag raised in bypass");

  char_error_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (sym_done_w && dec_error_w)
      |=> rx_char_error && sticky_reg[2'h0] && !$rose(rx_pend_reg))
    else $error("bad symbol not flagged");

endmodule
`default_nettype wire

// *** codec_pkg.sv ***
// constants shared by the serial character codec and its top level
package codec_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL        = 12'h000;
  localparam logic [11:0] ADDR_STATUS      = 12'h004;

  localparam int          CTRL_WIDTH8_BIT  = 0;
  localparam int          CTRL_EXTERNAL_FIFO_SELECT_BIT = 1;
  localparam int          CTRL_BYPASS_BIT  = 2;
  localparam logic [2:0]  CTRL_RESET       = 3'h1;

  localparam int          ST_AVAIL_BIT     = 0;
  localparam int          ST_TXBUSY_BIT    = 1;
  localparam int          ST_ALIGNED_BIT   = 2;
  localparam int          ST_CHARERR_BIT   = 3;
  localparam int          ST_RXOVR_BIT     = 4;
  localparam int          ST_TXOVR_BIT     = 5;
  localparam logic [2:0]  STICKY_RESET     = 3'h0;

  // ----------------------------------------------------------------------
  // symbol framing
  // ----------------------------------------------------------------------
  localparam logic [3:0]  SYM_LEN8         = 4'hA;
  localparam logic [3:0]  SYM_LEN10        = 4'hC;
  localparam logic [9:0]  SYNC8_SYMBOL     = 10'h311;
  localparam logic [11:0] SYNC10_SYMBOL    = 12'h623;

endpackage

// *** symbol_codec.sv ***
// combinational 4b/5b and 5b/6b encoder and decoder with command symbols
`timescale 1ns/1ps
`default_nettype none
module symbol_codec (
  input  wire logic        mode8,
  input  wire logic        bypass,
  input  wire logic [11:0] enc_word,
  input  wire logic        enc_special,
  output logic      [11:0] enc_symbol,
  input  wire logic [11:0] dec_symbol,
  output logic      [11:0] dec_word,
  output logic             dec_special,
  output logic             dec_error
);

  // ----------------------------------------------------------------------
  // code tables
  // ----------------------------------------------------------------------
  function automatic logic [4:0] enc4(input logic [3:0] d);
    unique case (d)
      4'h0: return 5'h1E;
      4'h1: return 5'h09;
      4'h2: return 5'h14;
      4'h3: return 5'h15;
      4'h4: return 5'h0A;
      4'h5: return 5'h0B;
      4'h6: return 5'h0E;
      4'h7: return 5'h0F;
      4'h8: return 5'h12;
      4'h9: return 5'h13;
      4'hA: return 5'h16;
      4'hB: return 5'h17;
      4'hC: return 5'h1A;
      4'hD: return 5'h1B;
      4'hE: return 5'h1C;
      4'hF: return 5'h1D;
    endcase
  endfunction

  function automatic logic [5:0] enc5(input logic [4:0] d);
    unique case (d)
      5'h00: return 6'h36;
      5'h01: return 6'h11;
      5'h02: return 6'h24;
      5'h03: return 6'h25;
      5'h04: return 6'h12;
      5'h05: return 6'h13;
      5'h06: return 6'h16;
      5'h07: return 6'h17;
      5'h08: return 6'h22;
      5'h09: return 6'h31;
      5'h0A: return 6'h37;
      5'h0B: return 6'h27;
      5'h0C: return 6'h32;
      5'h0D: return 6'h33;
      5'h0E: return 6'h34;
      5'h0F: return 6'h35;
      5'h10: return 6'h3E;
      5'h11: return 6'h19;
      5'h12: return 6'h29;
      5'h13: return 6'h2D;
      5'h14: return 6'h1A;
      5'h15: return 6'h1B;
      5'h16: return 6'h1E;
      5'h17: return 6'h1F;
      5'h18: return 6'h2A;
      5'h19: return 6'h2B;
      5'h1A: return 6'h2E;
      5'h1B: return 6'h2F;
      5'h1C: return 6'h3A;
      5'h1D: return 6'h3B;
      5'h1E: return 6'h3C;
      5'h1F: return 6'h3D;
    endcase
  endfunction

  function automatic logic [9:0] cmd8(input logic [3:0] i);
    unique case (i)
      4'h0: return codec_pkg::SYNC8_SYMBOL;
      4'h1: return 10'h3FF;
      4'h2: return 10'h1AD;
      4'h3: return 10'h1B9;
      4'h4: return 10'h3E4;
      4'h5: return 10'h1A7;
      4'h6: return 10'h327;
      4'h7: return 10'h339;
      4'h8: return 10'h084;
      4'h9: return 10'h09F;
      4'hA: return 10'h080;
      4'hB: return 10'h0E7;
      4'hC: return 10'h0F9;
      4'hD: return 10'h004;
      4'hE: return 10'h01F;
      4'hF: return 10'h000;
    endcase
  endfunction

  function automatic logic [11:0] cmd10(input logic [1:0] i);
    unique case (i)
      2'h0: return codec_pkg::SYNC10_SYMBOL;
      2'h1: return 12'hFFF;
      2'h2: return 12'h75D;
      2'h3: return 12'h779;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // reverse lookups: {hit, value}
  // ----------------------------------------------------------------------
  function automatic logic [4:0] dec4(input logic [4:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc4(4'(i)) == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] dec5(input logic [5:0] s);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 32; i++) begin
      if (enc5(5'(i)) == s) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] find8(input logic [9:0] s);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (cmd8(4'(i)) == s) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] find10(input logic [11:0] s);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (cmd10(2'(i)) == s) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // encode, left justified so bit 11 leaves first
  // ----------------------------------------------------------------------
  logic [11:0] enc8_w;
  logic [11:0] enc10_w;
  logic        special_w;

  assign special_w  = enc_special & ~bypass;
  assign enc8_w     = special_w ? {cmd8(enc_word[3:0]), 2'b00}
                    : {enc4(enc_word[7:4]), enc4(enc_word[3:0]), 2'b00};
  assign enc10_w    = special_w ? cmd10({enc_word[7], enc_word[0]})
                    : {enc5(enc_word[8:4]),
                       enc5({enc_word[9], enc_word[3:0]})};
  assign enc_symbol = bypass ? (mode8 ? {enc_word[9:0], 2'b00} : enc_word)
                    : (mode8 ? enc8_w : enc10_w);

  // ----------------------------------------------------------------------
  // decode, right justified input
  // ----------------------------------------------------------------------
  logic [4:0] hi4_w;
  logic [4:0] lo4_w;
  logic [5:0] g1_w;
  logic [5:0] g2_w;
  logic [4:0] c8_w;
  logic [2:0] c10_w;
  logic       ok8_w;
  logic       ok10_w;

  assign hi4_w  = dec4(dec_symbol[9:5]);
  assign lo4_w  = dec4(dec_symbol[4:0]);
  assign g1_w   = dec5(dec_symbol[11:6]);
  assign g2_w   = dec5(dec_symbol[5:0]);
  assign c8_w   = find8(dec_symbol[9:0]);
  assign c10_w  = find10(dec_symbol);
  assign ok8_w  = hi4_w[4] & lo4_w[4];
  assign ok10_w = g1_w[5] & g2_w[5];

  assign dec_word = bypass ? (mode8 ? {2'b00, dec_symbol[9:0]} : dec_symbol)
    : mode8 ? (ok8_w ? {4'h0, hi4_w[3:0], lo4_w[3:0]}
               : {8'h00, c8_w[3:0]})
    : (ok10_w ? {2'b00, g2_w[4], g1_w[4:0], g2_w[3:0]}
       : {4'h0, c10_w[1], 6'h00, c10_w[0]});
  assign dec_special = ~bypass & (mode8 ? ~ok8_w & c8_w[4]
                                        : ~ok10_w & c10_w[2]);
  assign dec_error   = ~bypass & (mode8 ? ~ok8_w & ~c8_w[4]
                                        : ~ok10_w & ~c10_w[2]);

endmodule
`default_nettype wire

// *** line_loop.sv ***
// serial line partner: loops the line back and recovers nrz bits
`timescale 1ns/1ps
`default_nettype none
module line_loop (
  input  wire logic clk,
  input  wire logic line_tx,
  output logic      line_rx,
  output logic      nrz_bit
);
  logic prev_reg;
  assign line_rx = line_tx;
  always_ff @(posedge clk) begin
    prev_reg <= line_tx;
    nrz_bit  <= line_tx ^ prev_reg;
  end
endmodule
`default_nettype wire

// *** tb_nrzi_4b5b_5b6b_codec.sv ***
// loopback bench for the serial character codec
`timescale 1ns/1ps
`default_nettype none
module tb_nrzi_4b5b_5b6b_codec;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        tx_special_char_select = 0, tx_write_enable = 1;
  logic        rx_port_enable = 1, rx_read_enable = 1, m8 = 1;
  logic [11:0] paddr = 12'h000, tx_parallel_word = 12'h000;
  logic [11:0] want = 12'h000, msk = 12'h0FF, win, rx_parallel_word;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, tx_busy, serial_out, serial_in, nrz_bit;
  logic        rx_special_char_flag, rx_data_available, rx_word_oe;
  logic        rx_char_error;
  int          err_count = 0, tests_run = 0, hits = 0, cycles = 0;

  always #50 clk = ~clk;

  nrzi_4b5b_5b6b_codec u_nrzi_4b5b_5b6b_codec (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .tx_parallel_word(tx_parallel_word),
    .tx_special_char_select(tx_special_char_select),
    .tx_write_enable(tx_write_enable), .tx_busy(tx_busy),
    .serial_out(serial_out), .serial_in(serial_in),
    .rx_port_enable(rx_port_enable), .rx_read_enable(rx_read_enable),
    .rx_parallel_word(rx_parallel_word),
    .rx_special_char_flag(rx_special_char_flag),
    .rx_data_available(rx_data_available), .rx_word_oe(rx_word_oe),
    .rx_char_error(rx_char_error));

  line_loop u_line_loop (
    .clk(clk), .line_tx(serial_out), .line_rx(serial_in),
    .nrz_bit(nrz_bit));

  // -------------------------------------------------------------------
  // line watch and timeout
  // -------------------------------------------------------------------
  always @(posedge clk) begin
    win <= {win[10:0], nrz_bit};
    if (m8 ? win[9:0] == want[9:0] : win == want) hits <= hits + 1;
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      finish_test;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd;
    rx_read_enable <= 1'b0;
    @(posedge clk);
    rx_read_enable <= 1'b1;
    @(posedge clk);
  endtask

  task automatic send(input logic ext, input logic [11:0] w);
    tx_parallel_word <= ext ? ~w : w;
    tx_write_enable <= ext;
    @(posedge clk);
    tx_write_enable <= ~ext;
    if (ext) begin
      tx_parallel_word <= w;
      @(posedge clk);
      tx_parallel_word <= ~w;
    end
  endtask

  task automatic xfer(input logic ext, inh, input logic [11:0] w, s);
    int h0;
    logic [11:0] old;
    h0 = hits;
    want = s;
    old = rx_parallel_word;
    send(ext, w);
    for (int i = 0; i < 300 && rx_data_available !== 1'b1; i++)
      @(posedge clk);
    chk("symbol", 1, hits != h0);
    chk("avail", 1, rx_data_available);
    if (inh) begin
      rx_port_enable <= 1'b0;
      repeat (2) @(posedge clk);
      chk("oe", 0, rx_word_oe);
      rd;
      chk("held", old, rx_parallel_word);
      chk("kept", 1, rx_data_available);
      rx_port_enable <= 1'b1;
      repeat (2) @(posedge clk);
    end
    rd;
    chk("word", w & msk, rx_parallel_word & msk);
    chk("empty", 0, rx_data_available);
  endtask

  task automatic t_regs;
    logic [31:0] r;
    logic        e;
    apb(1'b0, codec_pkg::ADDR_CTRL, 32'h0000_0000, r, e);
    chk("ctrl", 32'h0000_0001, r);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, r, e);
    apb(1'b0, 12'h010, 32'h0000_0000, r, e);
    chk("slverr", 1, e);
    chk("unmapped", 32'h0000_0000, r);
    $display("t_regs done");
  endtask

  task automatic t_byte;
    repeat (40) @(posedge clk);
    xfer(1'b0, 1'b1, 12'h05A, 12'h176);
    tx_special_char_select <= 1'b1;
    xfer(1'b0, 1'b0, 12'h001, 12'h3FF);
    chk("special", 1, rx_special_char_flag);
    tx_special_char_select <= 1'b0;
    $display("t_byte done");
  endtask

  task automatic t_ext;
    logic [31:0] r;
    logic        e;
    apb(1'b1, codec_pkg::ADDR_CTRL, 32'h0000_0003, r, e);
    tx_write_enable <= 1'b0;
    // mode switch with the enable high takes one stray word: drain it
    repeat (40) @(posedge clk);
    if (rx_data_available === 1'b1) rd;
    xfer(1'b1, 1'b0, 12'h00F, 12'h3DD);
    $display("t_ext done");
  endtask

  task automatic t_wide;
    logic [31:0] r;
    logic        e;
    apb(1'b1, codec_pkg::ADDR_CTRL, 32'h0000_0000, r, e);
    tx_write_enable <= 1'b1;
    m8 = 1'b0;
    msk = 12'h3FF;
    repeat (60) @(posedge clk);
    if (rx_data_available === 1'b1) rd;
    xfer(1'b0, 1'b0, 12'h200, 12'hDBE);
    xfer(1'b0, 1'b0, 12'h3FF, 12'hF7D);
    $display("t_wide done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_byte;
    t_ext;
    t_wide;
    finish_test;
  end
endmodule
`default_nettype wire
